// *** pkg/adc_rdo_pkg.sv ***
// Constants for the converter readout control: two-wire ready/data port,
// conversion framing, shift-clock hold detection, sync and power-down.
// Assumes clk is the converter system clock; counts are in its cycles except where marked as whole conversion cycles or half clocks.
// Functional notes
// - First low ready pulse only once the result is valid for the input.
// - Conversion cycle: 36-clock ready phase then 348-clock data phase.
// - Load result MSB first into shift register over 6 clocks, line high.
// - After load, line low 6 clocks, high 6 clocks, then data output.
// - Result MSB one keeps the line high after the ready phase.
// - Device changes bit on falling shift clock; reader samples on rising.
// - Without shift clocks the MSB stays until the final 24-clock high.
// - Partial read leaves the last shifted bit until the final high.
// - More than 24 shift clocks leave the line low until the final high.
// - Bit pointer resets at load start and at final high start.
// - After 4 high cycles: short low pulse, then high, modulator held reset.
// - Falling shift clock releases sync; first ready 2042.5 clocks later.
// - Sixteen further high cycles, twenty in all, enter power-down.
// - Falling shift clock ends power-down; valid ready 2318.5 clocks later.
// - Sync starts 1537 to 7679 clocks after the shift clock rises.
// - Power-down no sooner than 7681 clocks after the shift clock rises.
// - Result is 24-bit two's complement sent MSB first.
package adc_rdo_pkg;

  localparam int RESULT_W = 24;

  // Conversion framing, in system clocks
  localparam int CYCLE_CLK = 384;
  localparam int READY_CLK = 36;
  localparam int FINAL_HIGH_CLK = 24;
  localparam int LOAD_CLK = 6;
  localparam int LOW_CLK = 6;
  localparam int HIGH_CLK = 6;
  localparam int CNT_W = 9;

  // Phase positions inside the cycle; count 0 opens the final high interval
  localparam logic [8:0] PH_FINAL_HIGH = 9'h000;
  localparam logic [8:0] PH_LOAD = 9'(FINAL_HIGH_CLK - LOAD_CLK);
  localparam logic [8:0] PH_LOW = 9'(FINAL_HIGH_CLK);
  localparam logic [8:0] PH_HIGH = 9'(FINAL_HIGH_CLK + LOW_CLK);
  localparam logic [8:0] PH_DATA = 9'(READY_CLK);
  localparam logic [8:0] PH_LAST = 9'(CYCLE_CLK - 1);

  // Shift-clock hold thresholds, in whole conversion cycles
  localparam int SYNC_CYCLES = 4;
  localparam int PDOWN_CYCLES = 20;
  localparam int HOLD_W = 5;

  // Low pulse announcing sync; power-down entry has no pulse of its own
  localparam int SYNC_PULSE_CLK = 3;

  // Release-to-ready times, printed in half clocks, rounded up to clocks
  localparam int WAKE_SYNC_HALF = 4085;
  localparam int WAKE_PDOWN_HALF = 4637;
  localparam int WAKE_SYNC_CLK = (WAKE_SYNC_HALF + 1) / 2;
  localparam int WAKE_PDOWN_CLK = (WAKE_PDOWN_HALF + 1) / 2;
  localparam int WAIT_W = 12;

  // Bit pointer reset value and end count
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [4:0] PTR_END = 5'(RESULT_W);

  // Control states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_PULSE  = 3'b001,
    ST_HOLD   = 3'b010,
    ST_PDOWN  = 3'b011,
    ST_WAKE   = 3'b100
  } adc_rdo_state_t;

endpackage

// *** pkg/adc_rdo_sclk_if.sv ***
// Carries the sampled shift-clock level and its edge pulses between the
// input conditioner and the readout control. Single clock domain (clk).
`timescale 1ns/100ps
interface adc_rdo_sclk_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// *** core/adc_rdo_sclk_sync.sv ***
// Conditions the shift-clock pin into the clk domain: three flops, a new
// level is accepted once the second and third agree; edges are one-cycle.
`timescale 1ns/100ps
module adc_rdo_sclk_sync
  import adc_rdo_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    sclkPin,
  adc_rdo_sclk_if.src  sc
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic agree;
  logic level_d;

  // Only the second flop reads the first, so metastability stays contained
  assign agree   = (s2_q == s3_q);
  assign level_d = agree ? s3_q : level_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= sclkPin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  // Edge pulses come straight from the accepted level change
  assign sc.level = level_q;
  assign sc.rise  = ~level_q & level_d;
  assign sc.fall  = level_q & ~level_d;

endmodule

// *** core/adc_rdo_top.sv ***
// Readout control of the converter: frames each 384-clock conversion into
// a ready phase and a data phase on one output line, shifts the result out
// on falling shift-clock edges, and handles shift-clock hold for sync and
// power-down. Expects the filter to present resultData with resultValid
// high once results are settled; sclkPin comes from the reading party.
`timescale 1ns/100ps
module adc_rdo_top
  import adc_rdo_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                sclkPin,
  input  wire logic [RESULT_W-1:0] resultData,
  input  wire logic                resultValid,
  output logic                     readyDataLine,
  output logic                     modulatorReset,
  output logic                     powerDown,
  output logic                     resultLoad
);

  // Frame map, in counts of cnt_q while running:
  //   0..23    final high interval, line high, bit pointer cleared at 0
  //   18..23   result loaded into the shift register (load at count 18)
  //   24..29   ready low, or high while no settled result exists yet
  //   30..35   high before data
  //   36..383  data: current shift register MSB, low once 24 bits left
  // The line is registered, so it shows count n one clock after count n.
  //
  // Shift-clock path: pin, three sync flops, accepted fall pulse, shift
  // register, line flop. A pin fall reaches the line within five clocks,
  // which a reader with a short high half and long low half can tolerate.
  //
  // Hold detection samples the accepted level once per frame boundary.
  // The first high sample proves no whole frame, so sync needs five.
  // While the frame counter is frozen a private 384-clock count keeps the
  // boundary ticks going, so power-down is reached sixteen frames later.
  //
  // Limitation: the announce pulse follows count 383 directly; if the
  // line was low there, the low run seen outside is longer than 3 clocks.

  adc_rdo_sclk_if sc ();

  adc_rdo_sclk_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .sclkPin (sclkPin),
    .sc      (sc)
  );

  adc_rdo_state_t      state_q;
  adc_rdo_state_t      state_d;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;
  logic [RESULT_W-1:0] shreg_q;
  logic [RESULT_W-1:0] shreg_d;
  logic [4:0]          ptr_q;
  logic [4:0]          ptr_d;
  logic [HOLD_W-1:0]   hold_q;
  logic [HOLD_W-1:0]   hold_d;
  logic [WAIT_W-1:0]   wait_q;
  logic [WAIT_W-1:0]   wait_d;
  logic                fromPdown_q;
  logic                fromPdown_d;
  logic                valid_q;
  logic                valid_d;
  logic                line_q;
  logic                line_d;
  logic                load_q;

  // Phase decode of the running conversion cycle
  logic inFinalHigh;
  logic inLow;
  logic inData;
  logic atLoad;
  logic atStart;
  logic atLast;
  logic running;
  logic ptrDone;
  logic shiftNow;
  logic sampleHold;
  logic holdFull;
  logic reachSync;
  logic reachPdown;
  logic waitDone;
  logic inHoldState;
  logic [WAIT_W-1:0] wakeCount;

  // Private frame count used while the frame counter is frozen
  logic              holdTick;
  logic [WAIT_W-1:0] heldClk_q;
  logic [WAIT_W-1:0] heldClk_d;

  assign running     = (state_q == ST_RUN);
  assign atStart     = running && (cnt_q == PH_FINAL_HIGH);
  assign atLoad      = running && (cnt_q == PH_LOAD);
  assign atLast      = running && (cnt_q == PH_LAST);
  assign inFinalHigh = (cnt_q < PH_LOW);
  assign inLow       = (cnt_q >= PH_LOW) && (cnt_q < PH_HIGH);
  assign inData      = (cnt_q >= PH_DATA);
  assign ptrDone     = (ptr_q == PTR_END);
  // Shift only in the data phase; edges elsewhere are ignored
  assign shiftNow    = running && inData && sc.fall;

  // Hold is sampled once per cycle boundary; first sample proves no cycle
  assign inHoldState = (state_q == ST_PULSE) || (state_q == ST_HOLD);
  assign holdTick    = (heldClk_q == WAIT_W'(CYCLE_CLK - 1));
  assign sampleHold  = atLast || (inHoldState && holdTick);
  assign holdFull    = (hold_q == HOLD_W'(PDOWN_CYCLES + 1));
  assign reachSync   = atLast && sc.level &&
                       (hold_q == HOLD_W'(SYNC_CYCLES));
  assign reachPdown  = (state_q == ST_HOLD) && holdFull;

  // Release delay differs for sync and power-down
  assign wakeCount   = fromPdown_q ? WAIT_W'(WAKE_PDOWN_CLK - 1)
                                   : WAIT_W'(WAKE_SYNC_CLK - 1);
  assign waitDone    = (wait_q == wakeCount);

  // Cycle counter: wraps every 384 clocks while running
  always_comb begin
    cnt_d = cnt_q;
    if (running) begin
      cnt_d = atLast ? PH_FINAL_HIGH : cnt_q + 9'h001;
    end else if (state_d == ST_RUN) begin
      cnt_d = PH_FINAL_HIGH;
    end
  end

  // Hold counter in whole cycles, cleared whenever the level is low
  // It saturates one past the power-down count so it cannot wrap
  always_comb begin
    hold_d    = hold_q;
    heldClk_d = heldClk_q;
    if (!sc.level) begin
      hold_d    = '0;
      heldClk_d = '0;
    end else begin
      if (sampleHold && !holdFull) begin
        hold_d = hold_q + HOLD_W'(1);
      end
      if (running) begin
        heldClk_d = '0;
      end else if (inHoldState) begin
        // Frame counter is frozen here, so a private 384 count goes on
        heldClk_d = holdTick ? '0 : heldClk_q + WAIT_W'(1);
      end
    end
  end

  // Control state machine: run, announce, hold, power-down, wake
  always_comb begin
    state_d     = state_q;
    wait_d      = wait_q;
    fromPdown_d = fromPdown_q;
    unique case (state_q)
      ST_RUN: begin
        if (reachSync) begin
          state_d = ST_PULSE;
          wait_d  = '0;
        end
      end
      ST_PULSE: begin
        wait_d = wait_q + WAIT_W'(1);
        if (wait_q == WAIT_W'(SYNC_PULSE_CLK - 1)) begin
          state_d = ST_HOLD;
          wait_d  = '0;
        end
        if (sc.fall) begin
          state_d     = ST_WAKE;
          wait_d      = '0;
          fromPdown_d = 1'b0;
        end
      end
      ST_HOLD: begin
        if (sc.fall) begin
          state_d     = ST_WAKE;
          wait_d      = '0;
          fromPdown_d = 1'b0;
        end else if (reachPdown) begin
          state_d = ST_PDOWN;
        end
      end
      ST_PDOWN: begin
        if (sc.fall) begin
          state_d     = ST_WAKE;
          wait_d      = '0;
          fromPdown_d = 1'b1;
        end
      end
      ST_WAKE: begin
        wait_d = wait_q + WAIT_W'(1);
        if (waitDone) begin
          state_d = ST_RUN;
          wait_d  = '0;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Validity: settled filter sampled at count 0, which replaces the value forced in wake
  assign valid_d = (state_q == ST_WAKE) ? 1'b1
                 : (atStart ? resultValid : valid_q);

  // Shift register and bit pointer
  always_comb begin
    shreg_d = shreg_q;
    ptr_d   = ptr_q;
    if (atLoad) begin
      shreg_d = resultData;
      ptr_d   = PTR_RESET;
    end else if (atStart) begin
      ptr_d = PTR_RESET;
    end else if (shiftNow && !ptrDone) begin
      shreg_d = {shreg_q[RESULT_W-2:0], 1'b0};
      ptr_d   = ptr_q + 5'h01;
    end
  end

  // Line level: ready framing, then the current bit, low past 24 bits
  always_comb begin
    line_d = 1'b1;
    unique case (state_q)
      ST_RUN: begin
        if (inFinalHigh) begin
          line_d = 1'b1;
        end else if (inLow) begin
          line_d = ~valid_q;
        end else if (!inData) begin
          line_d = 1'b1;
        end else if (ptrDone) begin
          line_d = 1'b0;
        end else begin
          line_d = shreg_q[RESULT_W-1];
        end
      end
      ST_PULSE: line_d = 1'b0;
      ST_HOLD:  line_d = 1'b1;
      ST_PDOWN: line_d = 1'b1;
      ST_WAKE:  line_d = 1'b1;
      default:  line_d = 1'b1;
    endcase
  end

  // Clock-side registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_RUN;
      cnt_q       <= PH_FINAL_HIGH;
      hold_q      <= '0;
      heldClk_q   <= '0;
      wait_q      <= '0;
      fromPdown_q <= 1'b0;
      valid_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      hold_q      <= hold_d;
      heldClk_q   <= heldClk_d;
      wait_q      <= wait_d;
      fromPdown_q <= fromPdown_d;
      valid_q     <= valid_d;
    end
  end

  // Data path registers; line idles high out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg_q <= '0;
      ptr_q   <= PTR_RESET;
      line_q  <= 1'b1;
      load_q  <= 1'b0;
    end else begin
      shreg_q <= shreg_d;
      ptr_q   <= ptr_d;
      line_q  <= line_d;
      load_q  <= atLoad;
    end
  end

  // Registered outputs; modulator held in reset from announce to wake
  logic modRst_q;
  logic pdown_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modRst_q <= 1'b0;
      pdown_q  <= 1'b0;
    end else begin
      modRst_q <= (state_d == ST_PULSE) || (state_d == ST_HOLD) ||
                  (state_d == ST_PDOWN);
      pdown_q  <= (state_d == ST_PDOWN);
    end
  end

  assign readyDataLine  = line_q;
  assign modulatorReset = modRst_q;
  assign powerDown      = pdown_q;
  assign resultLoad     = load_q;

endmodule

// *** dv/adc_rdo_properties.sv ***
// Checker on the readout control ports: frame shape, result hand-off,
// hold detection, power-down and wake timing. Bound from the bench.
`timescale 1ns/100ps
module adc_rdo_properties
  import adc_rdo_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                sclkPin,
  input wire logic [RESULT_W-1:0] resultData,
  input wire logic                resultValid,
  input wire logic                readyDataLine,
  input wire logic                modulatorReset,
  input wire logic                powerDown,
  input wire logic                resultLoad
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [8:0]  sinceLoad_q;
  logic        framed_q;
  logic [13:0] sclkHigh_q;
  logic [13:0] modHigh_q;
  logic [3:0]  lowRun_q;
  logic [3:0]  lastLow_q;
  logic [11:0] wake_q;
  logic        waking_q;
  logic        pd_q;
  wire         wakeStart;

  // Pin seen low again while held: the wake stopwatch starts here
  assign wakeStart = modulatorReset && !sclkPin && sclkHigh_q != 14'h0000;

  // Long holds are counted here because repetitions cannot span them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceLoad_q <= '0;
      sclkHigh_q  <= '0;
      modHigh_q   <= '0;
      lowRun_q    <= '0;
    end else begin
      sinceLoad_q <= resultLoad ? 9'h000 : sinceLoad_q + 9'h001;
      sclkHigh_q  <= sclkPin ? sclkHigh_q + 14'h0001 : 14'h0000;
      modHigh_q   <= modulatorReset ? modHigh_q + 14'h0001 : 14'h0000;
      lowRun_q    <= readyDataLine ? 4'h0 : lowRun_q + 4'h1;
    end
  end

  // Last low run length, frame history and wake stopwatch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lastLow_q <= '0;
      framed_q  <= 1'b0;
      waking_q  <= 1'b0;
      wake_q    <= '0;
      pd_q      <= 1'b0;
    end else begin
      if (readyDataLine && lowRun_q != 4'h0)
        lastLow_q <= lowRun_q;
      framed_q <= resultLoad | (framed_q & ~modulatorReset);
      waking_q <= wakeStart | (waking_q & ~resultLoad);
      wake_q   <= waking_q ? wake_q + 12'h001 : 12'h000;
      if (!waking_q)
        pd_q <= powerDown;
    end
  end

  sequence lineHigh6;
    readyDataLine [*6];
  endsequence
  sequence lineLow6;
    (!readyDataLine) [*6];
  endsequence
  property readyShape;
    resultLoad && resultValid |-> lineHigh6 ##1 lineLow6 ##1 lineHigh6;
  endproperty

  ready_shape_a:
    assert property (readyShape) else $error("ready pulse shape");
  frame_period_a:
    assert property (resultLoad && framed_q |-> sinceLoad_q == 9'h17F)
    else $error("frame length");
  first_bit_a:
    assert property (resultLoad && resultValid |->
      ##18 readyDataLine == $past(resultData[RESULT_W-1], 18))
    else $error("first data bit");
  sync_pulse_a:
    assert property ($rose(modulatorReset) |->
      ##[0:5] (readyDataLine && lastLow_q == 4'h3))
    else $error("announce pulse");
  hold_high_a:
    assert property (modulatorReset && $past(modulatorReset, 4)
      |-> readyDataLine) else $error("line not high in hold");
  sync_start_a:
    assert property ($rose(modulatorReset) |->
      sclkHigh_q inside {[14'h0601:14'h1DFF]}) else $error("sync start");
  pdown_entry_a:
    assert property ($rose(powerDown) |->
      sclkHigh_q >= 14'h1E01 && modHigh_q >= 14'h17FC)
    else $error("power-down entry");
  pdown_mod_a:
    assert property (powerDown |-> modulatorReset) else $error("pd mod");
  wake_time_a:
    assert property (resultLoad && waking_q |->
      (wake_q - (pd_q ? 12'h114 : 12'h000)) inside {[12'h802:12'h820]})
    else $error("wake time");
endmodule

// *** dv/adc_rdo_reader.sv ***
// Reading controller model: shifts results in, holds the shift clock.
// Assumes it is started only outside the ready phase.
`timescale 1ns/100ps
module adc_rdo_reader (
  input  wire logic   line,
  output logic        sclk,
  output logic [23:0] word
);
  initial sclk = 1'b0;

  // 48 ns period, short high half: data settles well before each rise
  task automatic read(int n);
    word = '0;
    repeat (n) begin
      sclk = 1'b1;
      word = {word[22:0], line};
      #16 sclk = 1'b0;
      #32;
    end
  endtask

  task automatic level(logic v);
    sclk = v;
  endtask
endmodule

// *** dv/tb.sv ***
// Bench for the readout control: frames, reads, sync and power-down.
// Assumes the reader model drives the shift clock unrelated to clk.
`timescale 1ns/100ps
module tb;
  import adc_rdo_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                resultValid = 1'b0;
  logic [RESULT_W-1:0] resultData = 24'h80_0000;
  logic                readyDataLine;
  logic                modulatorReset;
  logic                powerDown;
  logic                resultLoad;
  logic                sclk;
  logic [RESULT_W-1:0] word;
  int                  badCount = 0;
  int                  checks = 0;

  always #2.5 clk = ~clk;

  adc_rdo_top dut (.clk(clk), .rst(rst), .sclkPin(sclk),
    .resultData(resultData), .resultValid(resultValid),
    .readyDataLine(readyDataLine), .modulatorReset(modulatorReset),
    .powerDown(powerDown), .resultLoad(resultLoad));
  adc_rdo_reader rdr (.line(readyDataLine), .sclk(sclk), .word(word));

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for the load pulse that opens each frame
  task automatic waitLoad();
    int n;
    n = 0;
    while (resultLoad !== 1'b1 && n < 2700) begin
      @(negedge clk);
      n++;
    end
    check("load pulse", resultLoad, 1'b1);
  endtask

  // First frame carries no valid result, so no low pulse may appear
  task automatic powerUp();
    waitLoad();
    repeat (8) @(negedge clk);
    check("early ready", readyDataLine, 1'b1);
    @(posedge clk) resultValid <= 1'b1;
  endtask

  // One frame: ready pulse, next result queued, read of n bits
  task automatic frame(logic [23:0] nxt, int n, logic [23:0] expW,
                       logic expLine);
    waitLoad();
    repeat (8) @(negedge clk);
    check("ready low", readyDataLine, 1'b0);
    @(posedge clk) resultData <= nxt;
    repeat (12) @(negedge clk);
    rdr.read(n);
    repeat (10) @(negedge clk);
    check("word", word, expW);
    if (expLine !== 1'bx)
      check("held bit", readyDataLine, expLine);
  endtask

  // Shift clock held high for whole frames, then released
  task automatic holdFor(int frames, logic expPd);
    @(posedge clk);
    rdr.level(1'b1);
    repeat (frames * 384) @(negedge clk);
    check("mod held", modulatorReset, 1'b1);
    check("line high", readyDataLine, 1'b1);
    check("power down", powerDown, expPd);
    rdr.level(1'b0);
    waitLoad();
    check("awake", powerDown, 1'b0);
    check("mod free", modulatorReset, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    powerUp();
    frame(24'h00_0000, 0, 24'h00_0000, 1'b1);
    frame(24'h5A_E3F1, 24, 24'h00_0000, 1'bx);
    frame(24'h7F_FFFF, 10, 24'h00_016B, 1'b1);
    frame(24'hA5_5A0F, 26, 24'hFF_FFFC, 1'b0);
    frame(24'h80_0000, 24, 24'hA5_5A0F, 1'bx);
    holdFor(7, 1'b0);
    frame(24'h80_0000, 24, 24'h80_0000, 1'bx);
    holdFor(24, 1'b1);
    frame(24'h00_0000, 24, 24'h80_0000, 1'bx);
    report_and_stop();
  end

  // Whole run is about 20k clocks; this cuts a hang short
  initial begin
    #300us;
    badCount++;
    report_and_stop();
  end
endmodule

bind adc_rdo_top adc_rdo_properties chk (.clk(clk), .rst(rst),
  .sclkPin(sclkPin), .resultData(resultData), .resultValid(resultValid),
  .readyDataLine(readyDataLine), .modulatorReset(modulatorReset),
  .powerDown(powerDown), .resultLoad(resultLoad));
